// ---- core/rfr_fault_top.sv ----
// Fault-response logic for the preregulator, the low-voltage buck and
// the boost converter, with its AHB-Lite register file.
// Assumes deglitched detector levels and cool-down levels synchronous
// to hclk, and a system controller that reads status and watches pins.
//
// Our own choices: the address map and the AHB-Lite slave port.
`timescale 1ns/1ps
module rfr_fault_top (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire rfr_pkg::rfr_fault_t pre_fault,
    input wire rfr_pkg::rfr_fault_t lv_fault,
    input wire rfr_pkg::rfr_fault_t boost_fault,
    input wire logic [2:0] rail_cool,
    output logic [2:0] rail_on,
    output logic reset_output_pin,
    output logic enable_drive_interrupt_pin,
    output logic irq
);
    import rfr_pkg::*;

    // One-hot rail whose register sits at base + stride * rail
    function automatic logic [2:0] rail_hit(input logic [7:0] addr,
                                            input logic [7:0] base);
        logic [2:0] hit;
        hit = 3'h0;
        for (int r = 0; r < RFR_RAILS; r++) begin
            hit[r] = (addr == 8'(base + 8'(r) * RFR_RAIL_STRIDE));
        end
        return hit;
    endfunction : rail_hit

    logic [7:0] reg_addr;
    logic reg_wr;
    logic [31:0] reg_wdata;
    logic [31:0] rd_data;

    rfr_state_t state;
    logic [2:0] ctrl_en;
    logic [5:0] cfg;
    logic [2:0] lock;
    logic all_off;
    logic [5:0] irq_stat;
    logic [5:0] irq_mask;

    rfr_fault_t fault_in [RFR_RAILS];
    rfr_flags_t flags [RFR_RAILS];
    rfr_fault_t rise [RFR_RAILS];
    logic [2:0] therm_wr;
    logic [2:0] curr_wr;

    logic go_off;
    logic pre_safe;
    logic go_safe;
    logic release_req;
    logic [2:0] en_clear;
    logic [2:0] lock_set;
    logic [2:0] warn_flag;
    logic warn_irq;
    logic [5:0] irq_set;
    logic next_reset_pin;
    logic next_edi_pin;
    logic [2:0] next_rail_on;

    // Bus front end
    rfr_ahb_slave u_bus (
        .hclk(hclk),
        .hresetn(hresetn),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hready(hready),
        .hwdata(hwdata),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .hrdata(hrdata),
        .reg_addr(reg_addr),
        .reg_wr(reg_wr),
        .reg_wdata(reg_wdata),
        .reg_rd_data(rd_data)
    );

    assign fault_in[RFR_PRE] = pre_fault;
    assign fault_in[RFR_LV] = lv_fault;
    assign fault_in[RFR_BOOST] = boost_fault;

    // Status register write strobes per rail
    assign therm_wr = rail_hit(reg_addr, RFR_OFS_THERM0) & {3{reg_wr}};
    assign curr_wr = rail_hit(reg_addr, RFR_OFS_CURR0) & {3{reg_wr}};

    // One flag block per rail; reverse sink is watched on every rail
    generate
        for (genvar g = 0; g < RFR_RAILS; g++) begin : g_rail
            rfr_rail_flags u_flags (
                .hclk(hclk),
                .hresetn(hresetn),
                .fault(fault_in[g]),
                .clr_thermal(therm_wr[g] ? reg_wdata[1:0] : 2'h0),
                .clr_current(curr_wr[g] ? reg_wdata[2:0] : 3'h0),
                .flags(flags[g]),
                .rise(rise[g])
            );
            assign warn_flag[g] = flags[g].thermal[RFR_TH_WARN];
            assign lock_set[g] = rise[g].ot_shut;
            assign irq_set[g] = |rise[g][4:3];
            assign irq_set[g + RFR_RAILS] = |rise[g][2:0];
        end
    endgenerate

    // Fault decisions; overload enters none of these terms
    always_comb begin
        go_off = (rise[RFR_PRE].ot_shut & cfg[RFR_CFG_PRE_THERM_OFF])
            | (rise[RFR_PRE].short_circ & cfg[RFR_CFG_PRE_SHORT_OFF])
            | (rise[RFR_PRE].reverse_sink & cfg[RFR_CFG_PRE_REV_OFF]);
        pre_safe = (rise[RFR_PRE].ot_shut | rise[RFR_PRE].short_circ
            | rise[RFR_PRE].reverse_sink) & ~go_off;
        en_clear = 3'h0;
        en_clear[RFR_LV] = rise[RFR_LV].ot_shut
            | rise[RFR_LV].short_circ | rise[RFR_LV].reverse_sink;
        en_clear[RFR_BOOST] = rise[RFR_BOOST].ot_shut
            | rise[RFR_BOOST].short_circ | rise[RFR_BOOST].reverse_sink;
        go_safe = pre_safe | en_clear[RFR_LV] | en_clear[RFR_BOOST];
    end

    // Software release of SAFE, ignored if a new fault arrives with it
    assign release_req = reg_wr && (reg_addr == RFR_OFS_CTRL)
        && reg_wdata[RFR_CTRL_RELEASE];

    // Operating state; OFF is left only through the device reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state <= RFR_ACTIVE;
        end else begin
            case (state)
                RFR_ACTIVE: begin
                    if (go_off) begin
                        state <= RFR_OFF;
                    end else if (go_safe) begin
                        state <= RFR_SAFE;
                    end
                end
                RFR_SAFE: begin
                    if (go_off) begin
                        state <= RFR_OFF;
                    end else if (release_req && !go_safe) begin
                        state <= RFR_ACTIVE;
                    end
                end
                RFR_OFF: begin
                    state <= RFR_OFF;
                end
                default: begin
                    state <= RFR_OFF;
                end
            endcase
        end
    end

    // All rails off after a preregulator SAFE entry, until released
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            all_off <= 1'b0;
        end else if (pre_safe || go_off) begin
            all_off <= 1'b1;
        end else if (release_req && state == RFR_SAFE && !go_safe) begin
            all_off <= 1'b0;
        end
    end

    // Regulator enable bits; a fault clear beats a simultaneous write
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_en <= RFR_EN_RST;
        end else begin
            if (reg_wr && reg_addr == RFR_OFS_CTRL) begin
                ctrl_en <= reg_wdata[RFR_CTRL_EN_LSB +: 3] & ~en_clear;
            end else begin
                ctrl_en <= ctrl_en & ~en_clear;
            end
        end
    end

    // Configuration: warning interrupt enables and off enables
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cfg <= RFR_CFG_RST;
        end else if (reg_wr && reg_addr == RFR_OFS_CFG) begin
            cfg <= reg_wdata[5:0];
        end
    end

    // Thermal lockout; a shutdown beats a cool-down in the same cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lock <= 3'h0;
        end else begin
            lock <= (lock & ~rail_cool) | lock_set;
        end
    end

    // Regulator drive: enabled, not locked, not cut by state
    always_comb begin
        next_rail_on = ctrl_en & ~lock & ~lock_set;
        next_rail_on = next_rail_on & ~en_clear;
        if (all_off || pre_safe || go_off || state == RFR_OFF) begin
            next_rail_on = 3'h0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rail_on <= 3'h0;
        end else begin
            rail_on <= next_rail_on;
        end
    end

    // Warning only reaches the pin through its enable
    assign warn_irq = |(warn_flag & cfg[RFR_CFG_WARN_IRQ_LSB +: 3]);

    // Pin levels: reset low only in OFF, interrupt pin low in SAFE,
    // OFF or on an enabled warning; the decision cycle counts already
    always_comb begin
        next_reset_pin = ~(go_off || state == RFR_OFF);
        next_edi_pin = 1'b1;
        if (go_off || go_safe || state != RFR_ACTIVE) begin
            next_edi_pin = 1'b0;
        end else if (warn_irq) begin
            next_edi_pin = 1'b0;
        end
    end

    // Pins leave reset high so the controller is not held in reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            reset_output_pin <= 1'b1;
            enable_drive_interrupt_pin <= 1'b1;
        end else begin
            reset_output_pin <= next_reset_pin;
            enable_drive_interrupt_pin <= next_edi_pin;
        end
    end

    // Interrupt status, write-one-to-clear; a new event beats its clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_stat <= 6'h00;
        end else if (reg_wr && reg_addr == RFR_OFS_IRQ_STAT) begin
            irq_stat <= (irq_stat & ~reg_wdata[5:0]) | irq_set;
        end else begin
            irq_stat <= irq_stat | irq_set;
        end
    end

    // Interrupt mask, one bit per status bit
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_mask <= RFR_IRQ_MASK_RST;
        end else if (reg_wr && reg_addr == RFR_OFS_IRQ_MASK) begin
            irq_mask <= reg_wdata[5:0];
        end
    end

    assign irq = |(irq_stat & irq_mask);

    // Read mux; unmapped offsets read as zero
    always_comb begin
        logic [2:0] th_sel;
        logic [2:0] cu_sel;
        th_sel = rail_hit(reg_addr, RFR_OFS_THERM0);
        cu_sel = rail_hit(reg_addr, RFR_OFS_CURR0);
        rd_data = 32'h0000_0000;
        for (int r = 0; r < RFR_RAILS; r++) begin
            if (th_sel[r]) begin
                rd_data[1:0] = flags[r].thermal;
            end
            if (cu_sel[r]) begin
                rd_data[2:0] = flags[r].current;
            end
        end
        case (reg_addr)
            RFR_OFS_CTRL: begin
                rd_data[RFR_CTRL_EN_LSB +: 3] = ctrl_en;
            end
            RFR_OFS_CFG: begin
                rd_data[5:0] = cfg;
            end
            RFR_OFS_IRQ_STAT: begin
                rd_data[5:0] = irq_stat;
            end
            RFR_OFS_IRQ_MASK: begin
                rd_data[5:0] = irq_mask;
            end
            RFR_OFS_STATE: begin
                rd_data[RFR_ST_STATE_LSB +: 3] = state;
                rd_data[RFR_ST_RESET_PIN] = reset_output_pin;
                rd_data[RFR_ST_EDI_PIN] = enable_drive_interrupt_pin;
                rd_data[RFR_ST_ALL_OFF] = all_off;
                rd_data[RFR_ST_RAIL_ON_LSB +: 3] = rail_on;
            end
            default: begin
                rd_data[31:6] = rd_data[31:6];
            end
        endcase
    end

endmodule : rfr_fault_top

// ---- core/rfr_pkg.sv ----
// Shared constants, state codes and carrier types of the regulator
// fault-response block.
// Assumes a 32-bit AHB-Lite register bus and synchronous fault inputs.
package rfr_pkg;

    // Rail indices
    localparam int RFR_PRE = 0;
    localparam int RFR_LV = 1;
    localparam int RFR_BOOST = 2;
    localparam int RFR_RAILS = 3;

    // Register byte offsets
    localparam logic [7:0] RFR_OFS_CTRL = 8'h00;
    localparam logic [7:0] RFR_OFS_CFG = 8'h04;
    localparam logic [7:0] RFR_OFS_THERM0 = 8'h10;
    localparam logic [7:0] RFR_OFS_CURR0 = 8'h1C;
    localparam logic [7:0] RFR_OFS_IRQ_STAT = 8'h28;
    localparam logic [7:0] RFR_OFS_IRQ_MASK = 8'h2C;
    localparam logic [7:0] RFR_OFS_STATE = 8'h30;
    localparam logic [7:0] RFR_RAIL_STRIDE = 8'h04;

    // Control register fields
    localparam int RFR_CTRL_EN_LSB = 0;
    localparam int RFR_CTRL_RELEASE = 8;
    localparam logic [2:0] RFR_EN_RST = 3'h7;

    // Configuration register fields
    localparam int RFR_CFG_WARN_IRQ_LSB = 0;
    localparam int RFR_CFG_PRE_THERM_OFF = 3;
    localparam int RFR_CFG_PRE_SHORT_OFF = 4;
    localparam int RFR_CFG_PRE_REV_OFF = 5;
    localparam logic [5:0] RFR_CFG_RST = 6'h00;

    // Thermal status fields
    localparam int RFR_TH_WARN = 0;
    localparam int RFR_TH_SHUT = 1;

    // Current status fields
    localparam int RFR_CU_SHORT = 0;
    localparam int RFR_CU_OVERLOAD = 1;
    localparam int RFR_CU_REVERSE = 2;

    // Interrupt status: bits 0..2 thermal per rail, 3..5 current per rail
    localparam int RFR_IRQ_BITS = 6;
    localparam logic [5:0] RFR_IRQ_MASK_RST = 6'h00;

    // State register fields
    localparam int RFR_ST_STATE_LSB = 0;
    localparam int RFR_ST_RESET_PIN = 4;
    localparam int RFR_ST_EDI_PIN = 5;
    localparam int RFR_ST_ALL_OFF = 6;
    localparam int RFR_ST_RAIL_ON_LSB = 8;

    // Operating state as seen by this block
    typedef enum logic [2:0] {
        RFR_ACTIVE = 3'b001,
        RFR_SAFE = 3'b010,
        RFR_OFF = 3'b100
    } rfr_state_t;

    // Deglitched detector levels of one rail
    typedef struct packed {
        logic ot_warn;
        logic ot_shut;
        logic short_circ;
        logic overload;
        logic reverse_sink;
    } rfr_fault_t;

    // Latched status flags of one rail
    typedef struct packed {
        logic [1:0] thermal;
        logic [2:0] current;
    } rfr_flags_t;

endpackage : rfr_pkg

// ---- core/rfr_ahb_slave.sv ----
// AHB-Lite slave front end: one wait state on every transfer.
// Assumes a single master and word accesses; response is always OKAY.
`timescale 1ns/1ps
module rfr_ahb_slave (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    output logic [7:0] reg_addr,
    output logic reg_wr,
    output logic [31:0] reg_wdata,
    input wire logic [31:0] reg_rd_data
);
    logic busy;
    logic done;
    logic write_q;
    logic take;

    // NONSEQ or SEQ while selected and the bus is ready
    assign take = hsel & htrans[1] & hready;

    // Address phase capture; hsize is accepted as a word in all cases
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            reg_addr <= 8'h00;
            write_q <= 1'b0;
        end else if (take) begin
            reg_addr <= {haddr[7:2], 2'b00};
            write_q <= hwrite;
        end
    end

    // Two-cycle data phase: busy (wait) then done (ready)
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            busy <= 1'b0;
            done <= 1'b0;
        end else begin
            busy <= take;
            done <= busy;
        end
    end

    // Read data sampled in the wait cycle so hrdata comes from a flop
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (busy && !write_q) begin
            hrdata <= reg_rd_data;
        end
    end

    assign hreadyout = ~busy;
    assign hresp = 1'b0;
    assign reg_wr = done & write_q;
    assign reg_wdata = hwdata;

endmodule : rfr_ahb_slave

// ---- core/rfr_rail_flags.sv ----
// Latched fault flags of one regulator with rising-edge event pulses.
// Assumes detector levels already deglitched and synchronous to hclk.
`timescale 1ns/1ps
module rfr_rail_flags (
    input wire logic hclk,
    input wire logic hresetn,
    input wire rfr_pkg::rfr_fault_t fault,
    input wire logic [1:0] clr_thermal,
    input wire logic [2:0] clr_current,
    output rfr_pkg::rfr_flags_t flags,
    output rfr_pkg::rfr_fault_t rise
);
    import rfr_pkg::*;

    rfr_fault_t prev;
    logic [1:0] set_thermal;
    logic [2:0] set_current;

    // Only a new detection counts, so a held level acts once
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            prev <= '0;
        end else begin
            prev <= fault;
        end
    end

    assign rise = fault & ~prev;

    always_comb begin
        set_thermal = 2'h0;
        set_current = 3'h0;
        set_thermal[RFR_TH_WARN] = rise.ot_warn;
        set_thermal[RFR_TH_SHUT] = rise.ot_shut;
        set_current[RFR_CU_SHORT] = rise.short_circ;
        set_current[RFR_CU_OVERLOAD] = rise.overload;
        set_current[RFR_CU_REVERSE] = rise.reverse_sink;
    end

    // Sticky flags, write-one-to-clear; a new event beats its clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flags <= '0;
        end else begin
            flags.thermal <= (flags.thermal & ~clr_thermal) | set_thermal;
            flags.current <= (flags.current & ~clr_current) | set_current;
        end
    end

endmodule : rfr_rail_flags

// ---- testbench/rfr_fault_props.sv ----
// Checker of the fault-response block: pin and bus relations over time.
// Sees only top-level ports; fault inputs are low around every reset.
`timescale 1ns/1ps
module rfr_fault_props (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire rfr_pkg::rfr_fault_t pre_fault,
    input wire rfr_pkg::rfr_fault_t lv_fault,
    input wire rfr_pkg::rfr_fault_t boost_fault,
    input wire logic [2:0] rail_on,
    input wire logic reset_output_pin,
    input wire logic enable_drive_interrupt_pin
);
    import rfr_pkg::*;

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // Bus handshake: one wait state after each taken address phase
    sequence s_taken;
        hsel && htrans[1] && hready;
    endsequence
    sequence s_wait;
        !hreadyout ##1 hreadyout;
    endsequence
    property p_one_wait;
        s_taken |=> s_wait;
    endproperty
    a_one_wait: assert property (p_one_wait)
        else $error("wait state count wrong");
    property p_okay;
        hresp == 1'b0;
    endproperty
    a_okay: assert property (p_okay)
        else $error("bus response not okay");

    // Trips are judged only while not already held in reset by OFF
    property p_lv_trip;
        ($rose(lv_fault.ot_shut) || $rose(lv_fault.short_circ) ||
            $rose(lv_fault.reverse_sink)) && reset_output_pin |=>
            !rail_on[1] && !enable_drive_interrupt_pin && reset_output_pin;
    endproperty
    a_lv_trip: assert property (p_lv_trip)
        else $error("low-voltage trip response wrong");
    property p_boost_trip;
        ($rose(boost_fault.ot_shut) || $rose(boost_fault.short_circ) ||
            $rose(boost_fault.reverse_sink)) && reset_output_pin |=>
            !rail_on[2] && !enable_drive_interrupt_pin && reset_output_pin;
    endproperty
    a_boost_trip: assert property (p_boost_trip)
        else $error("boost trip response wrong");
    property p_pre_trip;
        ($rose(pre_fault.ot_shut) || $rose(pre_fault.short_circ) ||
            $rose(pre_fault.reverse_sink)) && reset_output_pin |=>
            rail_on == 3'h0 && !enable_drive_interrupt_pin;
    endproperty
    a_pre_trip: assert property (p_pre_trip)
        else $error("preregulator trip response wrong");
    property p_off_hold;
        !reset_output_pin |=> !reset_output_pin &&
            !enable_drive_interrupt_pin && rail_on == 3'h0;
    endproperty
    a_off_hold: assert property (p_off_hold)
        else $error("off state left without reset");
    property p_overload;
        $rose(lv_fault.overload) && lv_fault == 5'h02 && pre_fault == 5'h00
            && boost_fault == 5'h00 && enable_drive_interrupt_pin
            && reset_output_pin |=> enable_drive_interrupt_pin &&
            reset_output_pin && $stable(rail_on);
    endproperty
    a_overload: assert property (p_overload)
        else $error("overload changed pins or rails");
    property p_warn_quiet;
        $rose(lv_fault.ot_warn) && lv_fault == 5'h10 && reset_output_pin
            |=> reset_output_pin && $stable(rail_on);
    endproperty
    a_warn_quiet: assert property (p_warn_quiet)
        else $error("warning changed state");
endmodule : rfr_fault_props

bind rfr_fault_top rfr_fault_props u_props (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .htrans(htrans),
    .hready(hready),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .pre_fault(pre_fault),
    .lv_fault(lv_fault),
    .boost_fault(boost_fault),
    .rail_on(rail_on),
    .reset_output_pin(reset_output_pin),
    .enable_drive_interrupt_pin(enable_drive_interrupt_pin)
);

// ---- testbench/rfr_mcu_model.sv ----
// System controller model: counts interrupt requests on the pin.
// Assumes the pin idles high and is sampled on hclk.
`timescale 1ns/1ps
module rfr_mcu_model (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic enable_drive_interrupt_pin,
    output logic [7:0] irq_falls
);
    logic pin_q;

    // Falling edges only, so a held-low pin counts once
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_q <= 1'b1;
            irq_falls <= 8'h00;
        end else begin
            pin_q <= enable_drive_interrupt_pin;
            if (pin_q && !enable_drive_interrupt_pin) begin
                irq_falls <= irq_falls + 8'h01;
            end
        end
    end
endmodule : rfr_mcu_model

// ---- testbench/regulator_fault_response_tb.sv ----
// Self-checking bench of the fault-response block over AHB-Lite.
// Assumes one wait state per transfer; faults raised as clean levels.
`timescale 1ns/1ps
module regulator_fault_response_tb;
    import rfr_pkg::*;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout, hresp, rst_pin, int_pin, irq;
    logic [31:0] hrdata, rd;
    rfr_fault_t pre_fault = '0, lv_fault = '0, boost_fault = '0;
    logic [2:0] rail_cool = 3'h7;
    logic [2:0] rail_on;
    logic [7:0] irq_falls;
    int err_count = 0;
    int n_checks = 0;

    // 25 MHz clock
    always #20 hclk = ~hclk;

    rfr_fault_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hready(hreadyout), .hwdata(hwdata), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .pre_fault(pre_fault),
        .lv_fault(lv_fault), .boost_fault(boost_fault),
        .rail_cool(rail_cool), .rail_on(rail_on),
        .reset_output_pin(rst_pin), .enable_drive_interrupt_pin(int_pin),
        .irq(irq));
    rfr_mcu_model mcu (.hclk(hclk), .hresetn(hresetn),
        .enable_drive_interrupt_pin(int_pin), .irq_falls(irq_falls));

    task automatic chk(input string n, input logic [31:0] e,
        input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            err_count++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    // Address phase held until ready, then data phase until ready
    task automatic xfer(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : xfer

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
        @(posedge hclk);
    endtask : wr

    task automatic hit(input int r, input logic [4:0] v);
        case (r)
            0: pre_fault <= v;
            1: lv_fault <= v;
            default: boost_fault <= v;
        endcase
        repeat (3) @(posedge hclk);
    endtask : hit

    // Reset pin is expected high in every state but OFF
    task automatic look(input string n, input logic [2:0] on,
        input logic [2:0] st, input logic e);
        @(posedge hclk);
        chk({n, " rails"}, 32'(on), 32'(rail_on));
        chk({n, " reset pin"}, 32'(st != 3'h4), 32'(rst_pin));
        chk({n, " int pin"}, 32'(e), 32'(int_pin));
        xfer(1'b0, RFR_OFS_STATE, 32'h0);
        chk({n, " state"}, 32'(st), 32'(rd[2:0]));
    endtask : look

    // Clear every flag, re-enable all rails and leave SAFE
    task automatic calm();
        for (int r = 0; r < 3; r++) begin
            wr(RFR_OFS_THERM0 + 8'(4 * r), 32'h3);
            wr(RFR_OFS_CURR0 + 8'(4 * r), 32'h7);
        end
        wr(RFR_OFS_IRQ_STAT, 32'h3F);
        wr(RFR_OFS_CTRL, 32'h107);
    endtask : calm

    task automatic t_reset();
        look("reset", 3'h7, 3'h1, 1'b1);
        wr(8'h3C, 32'hFFFFFFFF);
        xfer(1'b0, 8'h3C, 32'h0);
        chk("unmapped", 32'h0, rd);
        xfer(1'b0, RFR_OFS_CTRL, 32'h0);
        chk("ctrl", 32'h7, rd);
        xfer(1'b0, RFR_OFS_CFG, 32'h0);
        chk("cfg", 32'h0, rd);
        chk("irq", 32'h0, 32'(irq));
    endtask : t_reset

    task automatic t_warn();
        logic [7:0] n0;
        wr(RFR_OFS_IRQ_MASK, 32'h3F);
        hit(1, 5'h10);
        hit(1, 5'h00);
        look("quiet warn", 3'h7, 3'h1, 1'b1);
        xfer(1'b0, RFR_OFS_THERM0 + 8'h04, 32'h0);
        chk("warn flag", 32'h1, rd);
        chk("irq", 32'h1, 32'(irq));
        wr(RFR_OFS_IRQ_MASK, 32'h00);
        chk("masked irq", 32'h0, 32'(irq));
        wr(RFR_OFS_IRQ_MASK, 32'h3F);
        wr(RFR_OFS_IRQ_STAT, 32'h02);
        chk("cleared irq", 32'h0, 32'(irq));
        wr(RFR_OFS_THERM0 + 8'h04, 32'h1);
        xfer(1'b0, RFR_OFS_THERM0 + 8'h04, 32'h0);
        chk("warn cleared", 32'h0, rd);
        wr(RFR_OFS_CFG, 32'h02);
        n0 = irq_falls;
        hit(1, 5'h10);
        look("loud warn", 3'h7, 3'h1, 1'b0);
        chk("pin falls", 32'(n0 + 8'h01), 32'(irq_falls));
        hit(1, 5'h00);
        calm();
        look("warn gone", 3'h7, 3'h1, 1'b1);
        wr(RFR_OFS_CFG, 32'h00);
    endtask : t_warn

    // Shutdown, short and reverse sink on the low-voltage buck and boost
    task automatic t_rails();
        logic [4:0] v;
        logic [2:0] on;
        logic [7:0] a;
        for (int r = 1; r < 3; r++) begin
            for (int k = 0; k < 3; k++) begin
                v = (k == 2) ? 5'h01 : 5'h08 >> k;
                on = 3'h7 & ~(3'h1 << r);
                a = (k == 0) ? RFR_OFS_THERM0 : RFR_OFS_CURR0;
                if (k == 0) rail_cool <= on;
                hit(r, v);
                look("trip", on, 3'h2, 1'b0);
                xfer(1'b0, RFR_OFS_CTRL, 32'h0);
                chk("enables", 32'(on), rd);
                xfer(1'b0, a + 8'(4 * r), 32'h0);
                chk("flag", (k == 0) ? 2 : (k == 1) ? 1 : 4, rd);
                hit(r, 5'h00);
                calm();
                look("release", (k == 0) ? on : 3'h7, 3'h1, 1'b1);
                rail_cool <= 3'h7;
                repeat (3) @(posedge hclk);
                chk("cooled", 32'h7, 32'(rail_on));
            end
        end
    endtask : t_rails

    // Preregulator faults with each off enable clear, then set
    task automatic t_pre();
        logic [4:0] v;
        logic [2:0] st;
        for (int c = 0; c < 2; c++) begin
            for (int k = 0; k < 3; k++) begin
                v = (k == 2) ? 5'h01 : 5'h08 >> k;
                st = (c == 1) ? 3'h4 : 3'h2;
                wr(RFR_OFS_CFG, 32'(c) << (3 + k));
                hit(0, v);
                look("pre", 3'h0, st, 1'b0);
                hit(0, 5'h00);
                if (c == 1) begin
                    hresetn <= 1'b0;
                    repeat (8) @(posedge hclk);
                    hresetn <= 1'b1;
                    @(posedge hclk);
                end
                calm();
                look("pre back", 3'h7, 3'h1, 1'b1);
            end
        end
    endtask : t_pre

    task automatic t_load();
        for (int r = 0; r < 3; r++) begin
            hit(r, 5'h02);
            look("overload", 3'h7, 3'h1, 1'b1);
            xfer(1'b0, RFR_OFS_CURR0 + 8'(4 * r), 32'h0);
            chk("overload flag", 32'h2, rd);
            hit(r, 5'h00);
            calm();
        end
    endtask : t_load

    task automatic tally_and_finish();
        if (err_count == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : tally_and_finish

    // Watchdog: the whole sequence needs under a thousand cycles
    initial begin
        repeat (30000) @(posedge hclk);
        err_count++;
        tally_and_finish();
    end

    // Main sequence
    initial begin
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_reset();
        t_warn();
        t_load();
        t_rails();
        t_pre();
        tally_and_finish();
    end
endmodule : regulator_fault_response_tb
